// File: logic/pmr_bank.sv
`timescale 1ns/10ps
`include "pmr_regs.svh"
module pmr_bank #(
  parameter int NPORTS = 3
) (
  input  wire logic                               clk,
  input  wire logic                               rst,
  input  wire logic                               mdc,
  input  wire logic                               mdio_in,
  output      logic                               mdio_out,
  output      logic                               mdio_oe,
  input  wire pmr_pkg::pmr_spi_req_s              spi_req,
  output      pmr_pkg::pmr_spi_rsp_s              spi_rsp,
  input  wire pmr_pkg::pmr_stat_s [NPORTS-1:0]    port_stat,
  output      pmr_pkg::pmr_ctrl_s [NPORTS-1:0]    port_ctrl,
  output      logic [NPORTS-1:0][15:0]            port_adv
);
  import pmr_pkg::*;

  // ****************************************
  // register read decode
  // ****************************************
  pmr_stat_s [NPORTS-1:0] stat_q;

  function automatic logic [16:0] read_word(input pmr_ctrl_s c, input logic [15:0] a,
                                            input pmr_stat_s s, input logic [4:0] r);
    logic [15:0] w;
    logic        hit;
    w   = 16'h0000;
    hit = 1'b1;
    if (r == `PMR_REG_CTRL) begin
      w[`PMR_CTRL_DUPLEX]   = c.full_duplex;
      w[`PMR_CTRL_XALG]     = c.crossover_algorithm_select;
      w[`PMR_CTRL_STRAIGHT] = c.fixed_wiring_straight;
      w[`PMR_CTRL_XOFF]     = c.auto_crossover_off;
      w[`PMR_CTRL_FEF_OFF]  = c.far_fault_detect_off;
      w[`PMR_CTRL_TX_OFF]   = c.transmit_off;
      w[`PMR_CTRL_LED_OFF]  = c.indicator_off;               // bits 7..6 stay 0
    end else if (r == `PMR_REG_STATUS) begin
      w = `PMR_STAT_CAPS;
      w[`PMR_STAT_DONE]  = s.negotiation_done;
      w[`PMR_STAT_FAULT] = s.far_fault;
      w[`PMR_STAT_LINK]  = s.link_up;
    end else if (r == `PMR_REG_ID_HI) begin
      w = `PMR_ID_HI_VAL;
    end else if (r == `PMR_REG_ID_LO) begin
      w = `PMR_ID_LO_VAL;
    end else if (r == `PMR_REG_ADV) begin
      w = (a & `PMR_ADV_WMASK) | `PMR_ADV_FIXED;
    end else if (r == `PMR_REG_PARTNER) begin
      w = {2'b00, s.partner} & `PMR_PARTNER_MASK;
    end else if (r == `PMR_REG_DIAG || r == `PMR_REG_SPECIAL) begin
      w = 16'h0000;                                          // other blocks own these
    end else begin
      hit = 1'b0;
    end
    return {hit, w};
  endfunction

  function automatic pmr_ctrl_s ctrl_from(input logic [15:0] d);
    pmr_ctrl_s c;
    c.full_duplex                = d[`PMR_CTRL_DUPLEX];
    c.crossover_algorithm_select = d[`PMR_CTRL_XALG];
    c.fixed_wiring_straight      = d[`PMR_CTRL_STRAIGHT];
    c.auto_crossover_off         = d[`PMR_CTRL_XOFF];
    c.far_fault_detect_off       = d[`PMR_CTRL_FEF_OFF];
    c.transmit_off               = d[`PMR_CTRL_TX_OFF];
    c.indicator_off              = d[`PMR_CTRL_LED_OFF];
    return c;
  endfunction

  // ****************************************
  // management serial frame
  // ****************************************
  pmr_state_e  state;
  logic        mdc_q;
  logic [5:0]  pre_cnt;
  logic [4:0]  bit_cnt;
  logic [11:0] hdr;
  logic        is_read;
  logic [4:0]  frame_port;
  logic [4:0]  frame_reg;
  logic [15:0] shift;
  logic        mdio_wr;
  logic [4:0]  mdio_wr_port;
  logic [4:0]  mdio_wr_reg;
  logic [15:0] mdio_wr_data;

  wire         mdc_rise   = mdc & ~mdc_q;
  wire  [12:0] hdr_full   = {hdr, mdio_in};
  wire  [4:0]  hdr_port   = hdr_full[9:5];
  wire  [4:0]  hdr_reg    = hdr_full[4:0];
  wire  [1:0]  hdr_op     = hdr_full[11:10];
  wire         port_ok    = (hdr_port >= 5'd1) && (hdr_port <= 5'(NPORTS));
  wire  [4:0]  port_idx   = hdr_port - 5'd1;
  wire  [16:0] mdio_look  = port_ok ? read_word(port_ctrl[port_idx], port_adv[port_idx],
                                                stat_q[port_idx], hdr_reg) : 17'h0_0000;
  wire         op_ok      = (hdr_op == `PMR_OP_READ) || (hdr_op == `PMR_OP_WRITE);
  wire         frame_ok   = hdr_full[12] && op_ok && port_ok && mdio_look[16];
  wire         bit_last   = (bit_cnt == `PMR_DATA_BITS - 5'd1);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mdc_q <= 1'b0;
    end else begin
      mdc_q <= mdc;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state        <= PMR_IDLE;
      pre_cnt      <= 6'd0;
      bit_cnt      <= 5'd0;
      hdr          <= 12'h000;
      is_read      <= 1'b0;
      frame_port   <= 5'd0;
      frame_reg    <= 5'd0;
      shift        <= 16'h0000;
      mdio_out     <= 1'b0;
      mdio_oe      <= 1'b0;
      mdio_wr      <= 1'b0;
      mdio_wr_port <= 5'd0;
      mdio_wr_reg  <= 5'd0;
      mdio_wr_data <= 16'h0000;
    end else begin
      mdio_wr <= 1'b0;
      if (mdc_rise) begin
        case (state)
          PMR_IDLE: begin
            bit_cnt <= 5'd0;
            if (mdio_in) begin
              pre_cnt <= (pre_cnt == `PMR_PREAMBLE_MIN) ? pre_cnt : pre_cnt + 6'd1;
            end else if (pre_cnt == `PMR_PREAMBLE_MIN) begin
              state <= PMR_HDR;
            end else begin
              pre_cnt <= 6'd0;
            end
          end
          PMR_HDR: begin
            hdr     <= hdr_full[11:0];
            bit_cnt <= bit_cnt + 5'd1;
            if (bit_cnt == `PMR_HDR_BITS - 5'd1) begin
              // foreign or bad frames drop back; their data bits cannot form a preamble
              state      <= frame_ok ? PMR_TA : PMR_IDLE;
              pre_cnt    <= 6'd0;
              bit_cnt    <= 5'd0;
              is_read    <= (hdr_op == `PMR_OP_READ);
              frame_port <= port_idx;
              frame_reg  <= hdr_reg;
              shift      <= mdio_look[15:0];
            end
          end
          PMR_TA: begin
            bit_cnt <= bit_cnt + 5'd1;
            if (is_read && bit_cnt == 5'd0) begin
              mdio_oe  <= 1'b1;
              mdio_out <= 1'b0;
            end
            if (bit_cnt == `PMR_TA_BITS - 5'd1) begin
              bit_cnt <= 5'd0;
              state   <= is_read ? PMR_READ : PMR_WRITE;
              // first data bit must stand before the master samples it
              if (is_read) begin
                mdio_out <= shift[15];
                shift    <= {shift[14:0], 1'b0};
              end
            end
          end
          PMR_READ: begin
            mdio_out <= shift[15];
            shift    <= {shift[14:0], 1'b0};
            bit_cnt  <= bit_cnt + 5'd1;
            if (bit_last) begin
              mdio_oe  <= 1'b0;
              mdio_out <= 1'b0;
              state    <= PMR_IDLE;
            end
          end
          PMR_WRITE: begin
            shift   <= {shift[14:0], mdio_in};
            bit_cnt <= bit_cnt + 5'd1;
            if (bit_last) begin
              mdio_wr      <= 1'b1;
              mdio_wr_port <= frame_port;
              mdio_wr_reg  <= frame_reg;
              mdio_wr_data <= {shift[14:0], mdio_in};
              state        <= PMR_IDLE;
            end
          end
          default: begin
            state <= PMR_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************
  // serial host port access
  // ****************************************
  wire         spi_port_ok = (spi_req.phy_port_address >= 5'd1) &&
                             (spi_req.phy_port_address <= 5'(NPORTS));
  wire  [4:0]  spi_idx     = spi_req.phy_port_address - 5'd1;
  wire  [16:0] spi_look    = spi_port_ok ? read_word(port_ctrl[spi_idx], port_adv[spi_idx],
                                                     stat_q[spi_idx], spi_req.phy_register_address)
                                         : 17'h0_0000;
  wire         spi_wr      = spi_req.valid && spi_req.write && spi_look[16];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      spi_rsp <= '0;
    end else begin
      spi_rsp.valid <= spi_req.valid;
      spi_rsp.hit   <= spi_req.valid && spi_look[16];
      spi_rsp.rdata <= (spi_req.valid && !spi_req.write) ? spi_look[15:0] : 16'h0000;
    end
  end

  // ****************************************
  // per-port storage and status sampling
  // ****************************************
  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    // management frame wins a same-cycle clash with the host port
    wire         m_hit  = mdio_wr && (mdio_wr_port == 5'(p));
    wire         s_hit  = spi_wr && (spi_idx == 5'(p)) && !m_hit;
    wire  [4:0]  w_reg  = m_hit ? mdio_wr_reg : spi_req.phy_register_address;
    wire  [15:0] w_dat  = m_hit ? mdio_wr_data : spi_req.wdata;
    wire         w_ctrl = (m_hit || s_hit) && (w_reg == `PMR_REG_CTRL);
    wire         w_adv  = (m_hit || s_hit) && (w_reg == `PMR_REG_ADV);

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        port_ctrl[p]                            <= '0;
        port_ctrl[p].full_duplex                <= `PMR_CTRL_RST_DUPLEX;
        port_ctrl[p].crossover_algorithm_select <= `PMR_CTRL_RST_XALG;
        port_adv[p]                             <= `PMR_ADV_RST;
      end else begin
        if (w_ctrl) begin
          port_ctrl[p] <= ctrl_from(w_dat);
        end
        if (w_adv) begin
          port_adv[p] <= w_dat & `PMR_ADV_WMASK;  // fixed fields ignored
        end
      end
    end

    // fault report masked while detection is suppressed
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        stat_q[p] <= '0;
      end else begin
        stat_q[p].link_up          <= port_stat[p].link_up;
        stat_q[p].negotiation_done <= port_stat[p].negotiation_done;
        stat_q[p].far_fault        <= port_stat[p].far_fault & ~port_ctrl[p].far_fault_detect_off;
        stat_q[p].partner          <= port_stat[p].partner;
      end
    end
  end

endmodule

// File: pkg/pmr_regs.svh
`ifndef PMR_REGS_SVH
`define PMR_REGS_SVH

// ****************************************
// register addresses
// ****************************************
`define PMR_REG_CTRL       5'h00
`define PMR_REG_STATUS     5'h01
`define PMR_REG_ID_HI      5'h02
`define PMR_REG_ID_LO      5'h03
`define PMR_REG_ADV        5'h04
`define PMR_REG_PARTNER    5'h05
`define PMR_REG_DIAG       5'h1D
`define PMR_REG_SPECIAL    5'h1F

// ****************************************
// control fields and reset
// ****************************************
`define PMR_CTRL_DUPLEX    8
`define PMR_CTRL_XALG      5
`define PMR_CTRL_STRAIGHT  4
`define PMR_CTRL_XOFF      3
`define PMR_CTRL_FEF_OFF   2
`define PMR_CTRL_TX_OFF    1
`define PMR_CTRL_LED_OFF   0
`define PMR_CTRL_RST_DUPLEX 1'b1
`define PMR_CTRL_RST_XALG   1'b1

// ****************************************
// status fields
// ****************************************
`define PMR_STAT_CAPS      16'h7808
`define PMR_STAT_DONE      5
`define PMR_STAT_FAULT     4
`define PMR_STAT_LINK      2

// ****************************************
// identifier, arbitrary values
// ****************************************
`define PMR_ID_HI_VAL      16'h0A5C
`define PMR_ID_LO_VAL      16'h3C00

// ****************************************
// advertisement and partner
// ****************************************
`define PMR_ADV_FIXED      16'h0801
`define PMR_ADV_WMASK      16'h07E0
`define PMR_ADV_RST        16'h05E0
`define PMR_PARTNER_MASK   16'h3FFF

// ****************************************
// management frame timing
// ****************************************
`define PMR_PREAMBLE_MIN   6'd32
`define PMR_HDR_BITS       5'd13
`define PMR_DATA_BITS      5'd16
`define PMR_TA_BITS        5'd2
`define PMR_OP_READ        2'b10
`define PMR_OP_WRITE       2'b01

`endif

// File: pkg/pmr_pkg.sv
package pmr_pkg;

  typedef enum logic [2:0] {
    PMR_IDLE,
    PMR_HDR,
    PMR_TA,
    PMR_READ,
    PMR_WRITE
  } pmr_state_e;

  typedef struct packed {
    logic full_duplex;
    logic crossover_algorithm_select;
    logic fixed_wiring_straight;
    logic auto_crossover_off;
    logic far_fault_detect_off;
    logic transmit_off;
    logic indicator_off;
  } pmr_ctrl_s;

  typedef struct packed {
    logic        link_up;
    logic        far_fault;
    logic        negotiation_done;
    logic [13:0] partner;
  } pmr_stat_s;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [4:0]  phy_port_address;
    logic [4:0]  phy_register_address;
    logic [15:0] wdata;
  } pmr_spi_req_s;

  typedef struct packed {
    logic        valid;
    logic        hit;
    logic [15:0] rdata;
  } pmr_spi_rsp_s;

endpackage

// File: sim/pmr_bank_sva.sv
`timescale 1ns/10ps
`include "pmr_regs.svh"
module pmr_bank_sva #(
  parameter int NPORTS = 3
) (
  input wire logic                            clk,
  input wire logic                            rst,
  input wire logic                            mdc,
  input wire logic                            mdio_in,
  input wire logic                            mdio_out,
  input wire logic                            mdio_oe,
  input wire pmr_pkg::pmr_spi_req_s           spi_req,
  input wire pmr_pkg::pmr_spi_rsp_s           spi_rsp,
  input wire pmr_pkg::pmr_stat_s [NPORTS-1:0] port_stat,
  input wire pmr_pkg::pmr_ctrl_s [NPORTS-1:0] port_ctrl,
  input wire logic [NPORTS-1:0][15:0]         port_adv
);
  import pmr_pkg::*;
  // ********
  // last request, so a response can be matched to it
  // ********
  logic [4:0] last_reg;
  logic [4:0] last_port;
  logic       last_wr;
  wire        rd_ok = spi_rsp.valid && spi_rsp.hit && !last_wr;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_reg  <= 5'h00;
      last_port <= 5'h00;
      last_wr   <= 1'b0;
    end else begin
      last_reg  <= spi_req.phy_register_address;
      last_port <= spi_req.phy_port_address;
      last_wr   <= spi_req.write;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_rsp_next: assert property (spi_req.valid |=> spi_rsp.valid)
    else $error("host response missing");
  a_rsp_cause: assert property (spi_rsp.valid |-> $past(spi_req.valid))
    else $error("host response without request");
  a_miss_port: assert property (spi_rsp.valid && (last_port == 5'h00 || last_port > NPORTS) |-> !spi_rsp.hit)
    else $error("bad port answered");
  a_ctrl_rsvd: assert property (rd_ok && last_reg == `PMR_REG_CTRL |-> spi_rsp.rdata[7:6] == 2'b00)
    else $error("control reserved bits set");
  a_status_fixed: assert property (rd_ok && last_reg == `PMR_REG_STATUS |->
      spi_rsp.rdata[15:11] == 5'h0F && spi_rsp.rdata[10:6] == 5'h00 && spi_rsp.rdata[3] && spi_rsp.rdata[1:0] == 2'b00)
    else $error("status fixed bits wrong");
  a_id_words: assert property (rd_ok && last_reg == `PMR_REG_ID_HI |-> spi_rsp.rdata == `PMR_ID_HI_VAL)
    else $error("identifier upper wrong");
  a_id_low: assert property (rd_ok && last_reg == `PMR_REG_ID_LO |-> spi_rsp.rdata == `PMR_ID_LO_VAL)
    else $error("identifier lower wrong");
  a_adv_fixed: assert property (rd_ok && last_reg == `PMR_REG_ADV |-> spi_rsp.rdata[4:0] == 5'h01)
    else $error("selector field wrong");
  a_partner_rsvd: assert property (rd_ok && last_reg == `PMR_REG_PARTNER |-> spi_rsp.rdata[15:14] == 2'b00)
    else $error("partner reserved bits set");
  a_reset_ctrl: assert property ($fell(rst) |-> port_ctrl[0] == 7'h60 && port_adv[0] == `PMR_ADV_RST)
    else $error("control reset value wrong");
endmodule

bind pmr_bank pmr_bank_sva #(.NPORTS(NPORTS)) u_sva (.clk(clk), .rst(rst), .mdc(mdc), .mdio_in(mdio_in),
  .mdio_out(mdio_out), .mdio_oe(mdio_oe), .spi_req(spi_req), .spi_rsp(spi_rsp), .port_stat(port_stat),
  .port_ctrl(port_ctrl), .port_adv(port_adv));

// File: sim/pmr_mgmt_model.sv
`timescale 1ns/10ps
`include "pmr_regs.svh"
module pmr_mgmt_model (
  output logic      mdc,
  output logic      mdio_drv_oe,
  output logic      mdio_drv,
  input  wire logic mdio_line
);
  // half period of three system clocks, above the two-clock minimum
  localparam int HALF = 60;
  initial begin
    mdc = 1'b0;
    mdio_drv_oe = 1'b0;
    mdio_drv = 1'b0;
  end
  task automatic put_bit(input logic b);
    mdc = 1'b0;
    mdio_drv_oe = 1'b1;
    mdio_drv = b;
    #HALF;
    mdc = 1'b1;
    #HALF;
  endtask
  // full preamble every frame, so a refused frame never poisons the next
  task automatic frame(input logic [1:0] op, input logic [4:0] port, reg_a,
                       input logic [15:0] wdata, output logic [15:0] rdata);
    logic [45:0] hdr;
    hdr = {32'hFFFF_FFFF, 2'b01, op, port, reg_a};
    rdata = 16'h0000;
    for (int i = 45; i >= 0; i--) put_bit(hdr[i]);
    if (op == `PMR_OP_WRITE) begin
      put_bit(1'b1);
      put_bit(1'b0);
      for (int i = 15; i >= 0; i--) put_bit(wdata[i]);
    end else begin
      mdio_drv_oe = 1'b0;
      for (int i = 0; i < 18; i++) begin
        mdc = 1'b0;
        #HALF;
        if (i >= 2) rdata[17-i] = mdio_line;
        mdc = 1'b1;
        #HALF;
      end
    end
    // clock stands low between frames
    mdc = 1'b0;
    mdio_drv_oe = 1'b0;
    #HALF;
  endtask
endmodule

// File: sim/test_phy_mgmt_register_bank.sv
`timescale 1ns/10ps
`include "pmr_regs.svh"
module test_phy_mgmt_register_bank;
  import pmr_pkg::*;
  localparam int NPORTS = 3;
  logic                     clk;
  logic                     rst;
  logic                     mdc;
  logic                     mdio_out;
  logic                     mdio_oe;
  logic                     p_oe;
  logic                     p_drv;
  // pull-up holds the line high when nobody drives
  wire                      mdio_line = mdio_oe ? mdio_out : (p_oe ? p_drv : 1'b1);
  pmr_spi_req_s             spi_req;
  pmr_spi_rsp_s             spi_rsp;
  pmr_stat_s [NPORTS-1:0]   port_stat;
  pmr_ctrl_s [NPORTS-1:0]   port_ctrl;
  logic [NPORTS-1:0][15:0]  port_adv;
  logic [15:0]              rd;
  logic [15:0]              w;
  logic                     hit;
  logic [9:0]               miss [5] = '{10'h000, 10'h080, 10'h026, 10'h07C, 10'h05E};
  int                       num_errors;
  int                       checked;
  pmr_bank #(.NPORTS(NPORTS)) dut (.clk(clk), .rst(rst), .mdc(mdc), .mdio_in(mdio_line), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .spi_req(spi_req), .spi_rsp(spi_rsp), .port_stat(port_stat), .port_ctrl(port_ctrl),
    .port_adv(port_adv));
  pmr_mgmt_model u_mgmt (.mdc(mdc), .mdio_drv_oe(p_oe), .mdio_drv(p_drv), .mdio_line(mdio_line));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input string what, input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic spi(input logic wr, input logic [4:0] port, reg_a, input logic [15:0] wdata);
    @(posedge clk);
    #1;
    spi_req = {1'b1, wr, port, reg_a, wdata};
    @(posedge clk);
    #1;
    spi_req.valid = 1'b0;
    chk("response valid", {15'h0000, spi_rsp.valid}, 16'h0001);
    hit = spi_rsp.hit;
  endtask
  task automatic rd_chk(input logic [4:0] port, reg_a, input logic [15:0] exp);
    spi(1'b0, port, reg_a, 16'h0000);
    chk("read data", spi_rsp.rdata, exp);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #200_000;
    num_errors++;
    wrap_up();
  end
  initial begin
    rst = 1'b1;
    spi_req = '0;
    port_stat = '0;
    num_errors = 0;
    checked = 0;
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    for (int p = 1; p <= NPORTS; p++) begin
      rd_chk(p[4:0], `PMR_REG_CTRL, 16'h0120);
      rd_chk(p[4:0], `PMR_REG_STATUS, `PMR_STAT_CAPS);
      rd_chk(p[4:0], `PMR_REG_ID_HI, `PMR_ID_HI_VAL);
      rd_chk(p[4:0], `PMR_REG_ID_LO, `PMR_ID_LO_VAL);
      rd_chk(p[4:0], `PMR_REG_ADV, 16'h0DE1);
      rd_chk(p[4:0], `PMR_REG_PARTNER, 16'h0000);
      chk("ctrl out", {9'h000, port_ctrl[p-1]}, 16'h0060);
      chk("adv out", port_adv[p-1], `PMR_ADV_RST);
    end
    // walk one control bit at a time, including the unstored ones
    for (int i = 0; i < 16; i++) begin
      w = 16'h0001 << i;
      spi(1'b1, 5'd2, `PMR_REG_CTRL, w);
      rd_chk(5'd2, `PMR_REG_CTRL, w & 16'h013F);
      chk("ctrl out", {9'h000, port_ctrl[1]}, {9'h000, w[8], w[5:0]});
    end
    rd_chk(5'd1, `PMR_REG_CTRL, 16'h0120);
    spi(1'b1, 5'd3, `PMR_REG_ADV, 16'hFFFF);
    rd_chk(5'd3, `PMR_REG_ADV, 16'h0FE1);
    chk("adv out", port_adv[2], 16'h07E0);
    spi(1'b1, 5'd3, `PMR_REG_ADV, 16'h0000);
    rd_chk(5'd3, `PMR_REG_ADV, `PMR_ADV_FIXED);
    chk("adv out", port_adv[2], 16'h0000);
    spi(1'b1, 5'd1, `PMR_REG_STATUS, 16'hFFFF);
    spi(1'b1, 5'd1, `PMR_REG_ID_HI, 16'h0000);
    spi(1'b1, 5'd1, `PMR_REG_ID_LO, 16'h0000);
    spi(1'b1, 5'd1, `PMR_REG_PARTNER, 16'hFFFF);
    rd_chk(5'd1, `PMR_REG_ID_HI, `PMR_ID_HI_VAL);
    rd_chk(5'd1, `PMR_REG_ID_LO, `PMR_ID_LO_VAL);
    rd_chk(5'd1, `PMR_REG_STATUS, `PMR_STAT_CAPS);
    rd_chk(5'd1, `PMR_REG_PARTNER, 16'h0000);
    // distinct partner words catch a port index mix-up
    for (int p = 0; p < NPORTS; p++) port_stat[p] = {3'b111, 14'h1000 | p[13:0]};
    for (int p = 0; p < NPORTS; p++) begin
      rd_chk(p[4:0] + 5'd1, `PMR_REG_STATUS, 16'h783C);
      rd_chk(p[4:0] + 5'd1, `PMR_REG_PARTNER, 16'h1000 | p[15:0]);
    end
    spi(1'b1, 5'd1, `PMR_REG_CTRL, 16'h0124);
    rd_chk(5'd1, `PMR_REG_STATUS, 16'h782C);
    port_stat[0] = '0;
    rd_chk(5'd1, `PMR_REG_STATUS, `PMR_STAT_CAPS);
    for (int i = 0; i < 5; i++) begin
      rd_chk(miss[i][9:5], miss[i][4:0], 16'h0000);
      chk("hit", {15'h0000, hit}, 16'h0000);
    end
    rd_chk(5'd1, `PMR_REG_DIAG, 16'h0000);
    chk("hit", {15'h0000, hit}, 16'h0001);
    rd_chk(5'd2, `PMR_REG_SPECIAL, 16'h0000);
    chk("hit", {15'h0000, hit}, 16'h0001);
    @(posedge clk);
    #1;
    u_mgmt.frame(`PMR_OP_READ, 5'd1, `PMR_REG_ID_HI, 16'h0000, rd);
    chk("mdio read", rd, `PMR_ID_HI_VAL);
    u_mgmt.frame(`PMR_OP_WRITE, 5'd3, `PMR_REG_CTRL, 16'h0011, rd);
    rd_chk(5'd3, `PMR_REG_CTRL, 16'h0011);
    chk("ctrl out", {9'h000, port_ctrl[2]}, 16'h0011);
    @(posedge clk);
    #1;
    u_mgmt.frame(`PMR_OP_READ, 5'd3, `PMR_REG_ADV, 16'h0000, rd);
    chk("mdio read", rd, `PMR_ADV_FIXED);
    u_mgmt.frame(`PMR_OP_READ, 5'd4, `PMR_REG_ID_HI, 16'h0000, rd);
    chk("mdio refused", rd, 16'hFFFF);
    wrap_up();
  end
endmodule
